// ===== core/spi_pkg.sv
// Purpose: shared constants of the host spi slave port
// Assumes: byte-wide transfers, six-bit register address space
// Notes:   addresses and bit positions of the pull-down option are local choices
//==============================================================================
// package
package spi_pkg;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned ADDR_W     = 6;
    localparam int unsigned CNT_W      = 3;
    localparam int unsigned REG_COUNT  = 64;

    // mode field of the first byte, bits 7:6
    localparam logic [1:0] MODE_REG_WR = 2'h0;
    localparam logic [1:0] MODE_REG_RD = 2'h1;
    localparam logic [1:0] MODE_FIFO   = 2'h2;
    localparam logic [1:0] MODE_CMD    = 2'h3;

    // trailer patterns of a fifo access
    localparam logic [5:0] TRAILER_LOAD = 6'h00;
    localparam logic [5:0] TRAILER_READ = 6'h3f;

    // bit counter values
    localparam logic [CNT_W-1:0] CNT_ZERO  = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;
    localparam logic [CNT_W-1:0] CNT_PEEK  = 3'h6;
    localparam logic [CNT_W-1:0] CNT_LAST  = 3'h7;

    localparam logic [ADDR_W-1:0] ADDR_ONE  = 6'h01;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

    // location of the sdo pull-down option bits
    localparam logic [ADDR_W-1:0] PD_REG_ADDR = 6'h02;
    localparam int unsigned       PD_A_BIT    = 3;
    localparam int unsigned       PD_B_BIT    = 4;

    typedef enum logic [2:0] {
        ST_MODE    = 3'b000,
        ST_REG_WR  = 3'b001,
        ST_REG_RD  = 3'b010,
        ST_FIFO_LD = 3'b011,
        ST_FIFO_RD = 3'b100,
        ST_IGNORE  = 3'b101
    } port_state_e;
endpackage

// ===== core/reader_host_spi_slave.sv
// Purpose: four-wire spi slave port of the reader front end
// Assumes: spi mode with mosi sampled on falling sclk, miso launched on rising sclk
// Notes:   link logic runs on i_sclk; events reach i_core_clk through toggles
//
// Behaviour
// - port held in reset while select high
// - sample mosi falling, drive miso rising
// - eight-bit bytes, most significant bit first
// - top two bits of first byte choose mode
// - register address increments per extra byte
// - write commits on eighth falling clock edge
// - partial write byte is discarded
// - writes to missing or read-only registers ignored
// - missing register reads return zero byte
// - miso released except while shifting read data
// - pull-down on idle miso when both options
// - register access accepted at frame start or after a direct command
// - fifo load stores every following byte
// - partial fifo load byte is not stored
// - fifo read shifts successive fifo bytes out
// - partially read fifo byte stays unread
// - direct command launched on eighth falling edge
// - long command completion raises interrupt request
// - immediate command may chain next mode byte
// - interrupt output and host clock output offered
// - fifo mode holds; water-level interrupt suppressed
`timescale 1ns/1ps

//==============================================================================
// event crossing: toggle in, one-cycle pulse out
module event_sync (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    // event
    input  wire logic i_toggle,
    output logic      o_pulse
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= i_toggle;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign o_pulse = sync_ff ^ prev_ff;
endmodule

//==============================================================================
// spi slave port
module reader_host_spi_slave #(
    parameter logic [63:0] IMPL_MASK = 64'hffffffffffffffff,
    parameter logic [63:0] RO_MASK   = 64'h0000000000000000
) (
    // core clock and reset
    input  wire logic                           i_core_clk,
    input  wire logic                           i_resetn,
    // spi pins
    input  wire logic                           i_sclk,
    input  wire logic                           i_ss_n,
    input  wire logic                           i_mosi,
    output logic                                o_miso,
    output logic                                o_miso_oe_n,
    output logic                                o_miso_pulldown_en,
    // fifo view, quasi-static on the core clock
    input  wire logic [spi_pkg::BYTE_W-1:0]     i_fifo_head,
    input  wire logic [spi_pkg::BYTE_W-1:0]     i_fifo_next,
    output logic                                o_fifo_wr,
    output logic [spi_pkg::BYTE_W-1:0]          o_fifo_wdata,
    output logic                                o_fifo_rd,
    output logic                                o_fifo_mode,
    // direct command
    output logic                                o_cmd_valid,
    output logic [spi_pkg::ADDR_W-1:0]          o_cmd_code,
    input  wire logic                           i_long_cmd_done,
    // interrupt and host clock
    input  wire logic                           i_irq_src,
    input  wire logic                           i_fifo_wl_irq,
    input  wire logic                           i_irq_ack,
    input  wire logic                           i_osc_running,
    output logic                                o_irq,
    output logic                                o_mcu_clk
);
    import spi_pkg::*;

    //==========================================================================
    // link domain state
    logic                  port_rst_n;
    port_state_e           state_ff;
    port_state_e           nxt_state;
    logic [CNT_W-1:0]      bit_cnt_ff;
    logic [BYTE_W-2:0]     shift_ff;
    logic [BYTE_W-1:0]     rx_byte;
    logic                  byte_done;
    logic [ADDR_W-1:0]     addr_ff;
    logic [BYTE_W-1:0]     tx_byte_ff;
    logic [BYTE_W-1:0]     peek_ff;
    logic [BYTE_W-1:0]     reg_mem_ff [REG_COUNT];
    logic [BYTE_W-1:0]     rd_addr_data;
    logic [ADDR_W-1:0]     rd_addr;
    logic                  miso_ff;
    logic                  drive_ff;
    logic                  cmd_tgl_ff;
    logic [ADDR_W-1:0]     cmd_code_ff;
    logic                  wr_tgl_ff;
    logic [BYTE_W-1:0]     wr_data_ff;
    logic                  pop_tgl_ff;
    logic                  fifo_act_ff;

    assign port_rst_n = i_resetn & ~i_ss_n;
    assign rx_byte    = {shift_ff, i_mosi};
    assign byte_done  = (bit_cnt_ff == CNT_LAST);

    //==========================================================================
    // bit counter and shift register, sampled on falling sclk
    always_ff @(negedge i_sclk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            bit_cnt_ff <= CNT_ZERO;
            shift_ff   <= '0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + CNT_ONE;
            shift_ff   <= rx_byte[BYTE_W-2:0];
        end
    end

    //==========================================================================
    // mode decode of the first byte
    always_comb begin
        nxt_state = state_ff;
        if (byte_done) begin
            unique case (state_ff)
                ST_MODE: begin
                    unique case (rx_byte[7:6])
                        MODE_REG_WR: nxt_state = ST_REG_WR;
                        MODE_REG_RD: nxt_state = ST_REG_RD;
                        MODE_FIFO: begin
                            if (rx_byte[5:0] == TRAILER_LOAD) begin
                                nxt_state = ST_FIFO_LD;
                            end else if (rx_byte[5:0] == TRAILER_READ) begin
                                nxt_state = ST_FIFO_RD;
                            end else begin
                                nxt_state = ST_IGNORE;
                            end
                        end
                        MODE_CMD:    nxt_state = ST_MODE;
                    endcase
                end
                ST_REG_WR:  nxt_state = ST_REG_WR;
                ST_REG_RD:  nxt_state = ST_REG_RD;
                ST_FIFO_LD: nxt_state = ST_FIFO_LD;
                ST_FIFO_RD: nxt_state = ST_FIFO_RD;
                ST_IGNORE:  nxt_state = ST_IGNORE;
                default:    nxt_state = ST_IGNORE;
            endcase
        end
    end

    always_ff @(negedge i_sclk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            state_ff <= ST_MODE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    //==========================================================================
    // register address, auto-increment after every register data byte
    always_ff @(negedge i_sclk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            addr_ff <= '0;
        end else if (byte_done) begin
            if (state_ff == ST_MODE) begin
                addr_ff <= rx_byte[ADDR_W-1:0];
            end else if (state_ff == ST_REG_WR || state_ff == ST_REG_RD) begin
                addr_ff <= addr_ff + ADDR_ONE;
            end
        end
    end

    //==========================================================================
    // register storage, kept across select cycles
    always_ff @(negedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                reg_mem_ff[i] <= REG_RESET;
            end
        end else if (!i_ss_n && byte_done && state_ff == ST_REG_WR
                     && IMPL_MASK[addr_ff] && !RO_MASK[addr_ff]) begin
            reg_mem_ff[addr_ff] <= rx_byte;
        end
    end

    // address of the byte to send next: mode byte address or the incremented one
    assign rd_addr      = (state_ff == ST_MODE) ? rx_byte[ADDR_W-1:0] : addr_ff + ADDR_ONE;
    assign rd_addr_data = IMPL_MASK[rd_addr] ? reg_mem_ff[rd_addr] : BYTE_ZERO;

    //==========================================================================
    // transmit byte selection
    always_ff @(negedge i_sclk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            tx_byte_ff <= BYTE_ZERO;
            peek_ff    <= BYTE_ZERO;
        end else begin
            if (bit_cnt_ff == CNT_PEEK) begin
                peek_ff <= i_fifo_next;
            end
            if (byte_done) begin
                if (nxt_state == ST_REG_RD) begin
                    tx_byte_ff <= rd_addr_data;
                end else if (state_ff == ST_MODE && nxt_state == ST_FIFO_RD) begin
                    tx_byte_ff <= i_fifo_head;
                end else if (state_ff == ST_FIFO_RD) begin
                    tx_byte_ff <= peek_ff;
                end
            end
        end
    end

    //==========================================================================
    // miso launch on rising sclk
    always_ff @(posedge i_sclk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            miso_ff  <= 1'b0;
            drive_ff <= 1'b0;
        end else begin
            miso_ff  <= tx_byte_ff[CNT_LAST - bit_cnt_ff];
            drive_ff <= (state_ff == ST_REG_RD) || (state_ff == ST_FIFO_RD);
        end
    end

    assign o_miso             = miso_ff;
    assign o_miso_oe_n        = ~drive_ff;
    assign o_miso_pulldown_en = ~drive_ff & reg_mem_ff[PD_REG_ADDR][PD_A_BIT]
                                & reg_mem_ff[PD_REG_ADDR][PD_B_BIT];

    //==========================================================================
    // events toward the core, toggles survive select going high
    always_ff @(negedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_tgl_ff  <= 1'b0;
            cmd_code_ff <= '0;
            wr_tgl_ff   <= 1'b0;
            wr_data_ff  <= BYTE_ZERO;
            pop_tgl_ff  <= 1'b0;
        end else if (!i_ss_n && byte_done) begin
            if (state_ff == ST_MODE && rx_byte[7:6] == MODE_CMD) begin
                cmd_tgl_ff  <= ~cmd_tgl_ff;
                cmd_code_ff <= rx_byte[ADDR_W-1:0];
            end
            if (state_ff == ST_FIFO_LD) begin
                wr_tgl_ff  <= ~wr_tgl_ff;
                wr_data_ff <= rx_byte;
            end
            if (state_ff == ST_FIFO_RD) begin
                pop_tgl_ff <= ~pop_tgl_ff;
            end
        end
    end

    always_ff @(negedge i_sclk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            fifo_act_ff <= 1'b0;
        end else begin
            fifo_act_ff <= (nxt_state == ST_FIFO_LD) || (nxt_state == ST_FIFO_RD);
        end
    end

    //==========================================================================
    // core domain
    logic       cmd_pulse;
    logic       wr_pulse;
    logic       pop_pulse;
    logic       act_meta_ff;
    logic       act_sync_ff;
    logic       osc_meta_ff;
    logic       osc_sync_ff;
    logic       cmd_valid_ff;
    logic [ADDR_W-1:0] cmd_code_out_ff;
    logic       fifo_wr_ff;
    logic [BYTE_W-1:0] fifo_wdata_ff;
    logic       fifo_rd_ff;
    logic       done_pend_ff;
    logic       irq_ff;
    logic       mcu_clk_ff;

    event_sync u_cmd_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_toggle   (cmd_tgl_ff),
        .o_pulse    (cmd_pulse)
    );

    event_sync u_wr_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_toggle   (wr_tgl_ff),
        .o_pulse    (wr_pulse)
    );

    event_sync u_pop_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_toggle   (pop_tgl_ff),
        .o_pulse    (pop_pulse)
    );

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            act_meta_ff <= 1'b0;
            act_sync_ff <= 1'b0;
            osc_meta_ff <= 1'b0;
            osc_sync_ff <= 1'b0;
        end else begin
            act_meta_ff <= fifo_act_ff;
            act_sync_ff <= act_meta_ff;
            osc_meta_ff <= i_osc_running;
            osc_sync_ff <= osc_meta_ff;
        end
    end

    // event outputs; data words are stable long before the toggle arrives
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_valid_ff    <= 1'b0;
            cmd_code_out_ff <= '0;
            fifo_wr_ff      <= 1'b0;
            fifo_wdata_ff   <= BYTE_ZERO;
            fifo_rd_ff      <= 1'b0;
        end else begin
            cmd_valid_ff <= cmd_pulse;
            fifo_wr_ff   <= wr_pulse;
            fifo_rd_ff   <= pop_pulse;
            if (cmd_pulse) begin
                cmd_code_out_ff <= cmd_code_ff;
            end
            if (wr_pulse) begin
                fifo_wdata_ff <= wr_data_ff;
            end
        end
    end

    // interrupt request: set wins over acknowledge
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            done_pend_ff <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            if (i_long_cmd_done) begin
                done_pend_ff <= 1'b1;
            end else if (i_irq_ack) begin
                done_pend_ff <= 1'b0;
            end
            irq_ff <= i_irq_src | done_pend_ff | (i_fifo_wl_irq & ~act_sync_ff);
        end
    end

    // host clock, half the core rate while the oscillator runs
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mcu_clk_ff <= 1'b0;
        end else if (osc_sync_ff) begin
            mcu_clk_ff <= ~mcu_clk_ff;
        end else begin
            mcu_clk_ff <= 1'b0;
        end
    end

    assign o_cmd_valid  = cmd_valid_ff;
    assign o_cmd_code   = cmd_code_out_ff;
    assign o_fifo_wr    = fifo_wr_ff;
    assign o_fifo_wdata = fifo_wdata_ff;
    assign o_fifo_rd    = fifo_rd_ff;
    assign o_fifo_mode  = act_sync_ff;
    assign o_irq        = irq_ff;
    assign o_mcu_clk    = mcu_clk_ff;
endmodule

// ===== test/reader_host_spi_slave_props.sv
// Purpose: concurrent checks on the host spi slave port
// Assumes: core clock domain, asynchronous active-low reset
// Notes:   serial-side timing is judged by the bench
`timescale 1ns/1ps
//==============================================================================
// checker
module reader_host_spi_slave_props (
    input wire logic                       i_core_clk,
    input wire logic                       i_resetn,
    input wire logic                       i_ss_n,
    input wire logic                       o_miso_oe_n,
    input wire logic                       o_miso_pulldown_en,
    input wire logic                       o_fifo_wr,
    input wire logic                       o_fifo_mode,
    input wire logic                       o_cmd_valid,
    input wire logic [spi_pkg::ADDR_W-1:0] o_cmd_code,
    input wire logic                       i_long_cmd_done,
    input wire logic                       i_irq_src,
    input wire logic                       i_fifo_wl_irq,
    input wire logic                       i_irq_ack,
    input wire logic                       i_osc_running,
    input wire logic                       o_irq,
    input wire logic                       o_mcu_clk
);
    import spi_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    // no interrupt cause: no long command completion, other source or water-level request
    sequence quiet_s;
        !i_long_cmd_done && !i_irq_src && !i_fifo_wl_irq;
    endsequence
    sequence fifo_calm_s;
        (o_fifo_mode && !i_irq_src && !i_long_cmd_done && !o_irq) [*2];
    endsequence

    oe_released_a: assert property (i_ss_n |-> o_miso_oe_n)
        else $error("miso driven while deselected");
    mode_release_a: assert property (i_ss_n [*3] |-> !o_fifo_mode)
        else $error("fifo mode kept after deselect");
    pulldown_idle_a: assert property (o_miso_pulldown_en |-> o_miso_oe_n)
        else $error("pull-down active while miso driven");
    fifo_wr_pulse_a: assert property (o_fifo_wr |=> !o_fifo_wr)
        else $error("fifo write pulse longer than one cycle");
    cmd_hold_a: assert property (o_cmd_valid |=> !o_cmd_valid && $stable(o_cmd_code))
        else $error("command pulse or code not held");
    irq_set_a: assert property (i_long_cmd_done |-> ##[1:3] o_irq)
        else $error("no interrupt after long command");
    irq_clear_a: assert property (i_irq_ack ##0 quiet_s ##1 quiet_s [*3] |-> !o_irq)
        else $error("interrupt stays after acknowledge");
    wl_masked_a: assert property (fifo_calm_s |=> !o_irq)
        else $error("water-level interrupt during fifo mode");
    mcu_run_a: assert property (i_osc_running [*4] |-> o_mcu_clk != $past(o_mcu_clk))
        else $error("host clock not toggling");
    mcu_stop_a: assert property (!i_osc_running [*4] |-> !o_mcu_clk)
        else $error("host clock running without oscillator");
endmodule

bind reader_host_spi_slave reader_host_spi_slave_props u_props (
    .i_core_clk (i_core_clk), .i_resetn (i_resetn), .i_ss_n (i_ss_n),
    .o_miso_oe_n (o_miso_oe_n), .o_miso_pulldown_en (o_miso_pulldown_en),
    .o_fifo_wr (o_fifo_wr), .o_fifo_mode (o_fifo_mode), .o_cmd_valid (o_cmd_valid),
    .o_cmd_code (o_cmd_code), .i_long_cmd_done (i_long_cmd_done), .i_irq_src (i_irq_src),
    .i_fifo_wl_irq (i_fifo_wl_irq), .i_irq_ack (i_irq_ack),
    .i_osc_running (i_osc_running), .o_irq (o_irq), .o_mcu_clk (o_mcu_clk)
);

// ===== test/spi_host_model.sv
// Purpose: host microcontroller acting as spi master
// Assumes: sclk idles low, mosi changed while sclk low
// Notes:   sclk runs only inside bytes; byte gaps let core events settle
`timescale 1ns/1ps
//==============================================================================
// spi master
module spi_host_model (
    // serial lines
    input  wire logic i_sdo,
    output logic      o_sclk,
    output logic      o_ss_n,
    output logic      o_mosi
);
    initial begin
        o_sclk = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b0;
    end

    // select on or off, then the setup or idle hold
    task automatic sel(input logic on);
        o_ss_n = !on;
        #150;
    endtask

    // nbits of tx msb first; rx taken just before each falling sclk
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        // mosi moves 1 ns after the falling edge so the slave never sees the next bit
        for (int i = 7; i > 7 - nbits; i--) begin
            #1 o_mosi = tx[i];
            #2 o_sclk = 1'b1;
            #3 rx[i] = i_sdo;
            o_sclk = 1'b0;
        end
        #1 o_mosi = ~o_mosi;
        #300;
    endtask
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench of the host spi slave port
// Assumes: host model drives the serial lines, bench drives the core side
// Notes:   address 0x10 is unimplemented and 0x11 read-only here
`timescale 1ns/1ps
//==============================================================================
// bench
module testbench;
    import spi_pkg::*;
    logic       clk, resetn, sclk, ss_n, mosi, miso, oe_n, pd_en, sdo;
    logic       fifo_wr, fifo_rd, fifo_mode, cmd_valid, long_done, irq_src;
    logic       wl_irq, irq_ack, osc, irq, mcu_clk;
    logic [7:0] head, fnext, wdata;
    logic [5:0] code;
    logic [7:0] got[$];
    int         bad_count, check_count, cyc, wr_n, rd_n, cmd_n;

    // released miso follows the pull-down, else a moving pattern
    assign sdo = !oe_n ? miso : (pd_en ? 1'b0 : ~mosi);

    reader_host_spi_slave #(
        .IMPL_MASK (64'hfffffffffffeffff),
        .RO_MASK   (64'h0000000000020000)
    ) u_reader_host_spi_slave (
        .i_core_clk (clk), .i_resetn (resetn), .i_sclk (sclk), .i_ss_n (ss_n),
        .i_mosi (mosi), .o_miso (miso), .o_miso_oe_n (oe_n), .o_miso_pulldown_en (pd_en),
        .i_fifo_head (head), .i_fifo_next (fnext), .o_fifo_wr (fifo_wr),
        .o_fifo_wdata (wdata), .o_fifo_rd (fifo_rd), .o_fifo_mode (fifo_mode),
        .o_cmd_valid (cmd_valid), .o_cmd_code (code), .i_long_cmd_done (long_done),
        .i_irq_src (irq_src), .i_fifo_wl_irq (wl_irq), .i_irq_ack (irq_ack),
        .i_osc_running (osc), .o_irq (irq), .o_mcu_clk (mcu_clk)
    );
    spi_host_model host (.i_sdo (sdo), .o_sclk (sclk), .o_ss_n (ss_n), .o_mosi (mosi));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // event counters and the hang limit
    always @(posedge clk) begin
        cyc++;
        wr_n += int'(fifo_wr === 1'b1);
        rd_n += int'(fifo_rd === 1'b1);
        cmd_n += int'(cmd_valid === 1'b1);
        if (cyc == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask

    // one select-low period; the last byte may be cut short
    task automatic frame(input logic [7:0] q[$], input int last_bits);
        logic [7:0] rx;
        got = {};
        host.sel(1'b1);
        foreach (q[i]) begin
            host.xfer(q[i], (i == q.size() - 1) ? last_bits : 8, rx);
            got.push_back(rx);
        end
        host.sel(1'b0);
    endtask

    task automatic wait_core(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reg();
        frame('{8'h3f, 8'ha5, 8'h5a}, 8);
        frame('{8'h7f, 8'h00, 8'h00}, 8);
        chk("reg 3f", 8'ha5, got[1]);
        chk("reg 00 after wrap", 8'h5a, got[2]);
        frame('{8'h05, 8'hff}, 5);
        frame('{8'h45, 8'h00}, 8);
        chk("reg 05 partial", 8'h00, got[1]);
        frame('{8'h10, 8'h77, 8'h66, 8'h55}, 8);
        frame('{8'h50, 8'h00, 8'h00, 8'h00}, 8);
        chk("reg 10 missing", 8'h00, got[1]);
        chk("reg 11 read-only", 8'h00, got[2]);
        chk("reg 12", 8'h55, got[3]);
        $display("test registers done");
    endtask

    task automatic t_fifo();
        int w0;
        int r0;
        logic [7:0] rx;
        @(posedge clk) head <= 8'h3c;
        fnext <= 8'hc3;
        wl_irq <= 1'b1;
        w0 = wr_n;
        frame('{8'h80, 8'h11, 8'h22, 8'h33}, 3);
        chk("fifo writes", 8'h02, 8'(wr_n - w0));
        chk("fifo wdata", 8'h22, wdata);
        wait_core(4);
        chk("water irq after frame", 8'h01, {7'h0, irq});
        @(posedge clk) wl_irq <= 1'b0;
        r0 = rd_n;
        frame('{8'hbf, 8'h00, 8'h00}, 8);
        chk("fifo byte 0", 8'h3c, got[1]);
        chk("fifo byte 1", 8'hc3, got[2]);
        chk("fifo pops", 8'h02, 8'(rd_n - r0));
        frame('{8'hbf, 8'h00}, 4);
        chk("partial pop", 8'h02, 8'(rd_n - r0));
        frame('{8'hbf, 8'h00}, 8);
        chk("fifo reread", 8'h3c, got[1]);
        host.sel(1'b1);
        host.xfer(8'hbf, 8, rx);
        chk("fifo mode held", 8'h01, {7'h0, fifo_mode});
        host.sel(1'b0);
        wait_core(3);
        chk("fifo mode released", 8'h00, {7'h0, fifo_mode});
        $display("test fifo done");
    endtask

    task automatic t_cmd();
        int c0;
        logic m;
        c0 = cmd_n;
        frame('{8'hc5, 8'h7f, 8'h00}, 8);
        chk("commands", 8'h01, 8'(cmd_n - c0));
        chk("command code", 8'h05, {2'h0, code});
        chk("chained read", 8'ha5, got[2]);
        @(posedge clk) long_done <= 1'b1;
        @(posedge clk) long_done <= 1'b0;
        wait_core(3);
        chk("irq set", 8'h01, {7'h0, irq});
        @(posedge clk) irq_ack <= 1'b1;
        @(posedge clk) irq_ack <= 1'b0;
        wait_core(3);
        chk("irq clear", 8'h00, {7'h0, irq});
        @(posedge clk) irq_src <= 1'b1;
        wait_core(3);
        chk("irq other source", 8'h01, {7'h0, irq});
        @(posedge clk) irq_src <= 1'b0;
        osc <= 1'b1;
        wait_core(6);
        m = mcu_clk;
        wait_core(1);
        chk("host clock", {7'h0, ~m}, {7'h0, mcu_clk});
        @(posedge clk) osc <= 1'b0;
        wait_core(6);
        $display("test command and irq done");
    endtask

    task automatic t_pd();
        frame('{8'h02, 8'h18}, 8);
        chk("pull-down on", 8'h01, {7'h0, pd_en});
        chk("miso released", 8'h01, {7'h0, oe_n});
        frame('{8'h02, 8'h08}, 8);
        chk("pull-down one option", 8'h00, {7'h0, pd_en});
        $display("test pull-down done");
    endtask

    initial begin
        resetn = 1'b0;
        head = 8'h00;
        fnext = 8'h00;
        long_done = 1'b0;
        irq_src = 1'b0;
        wl_irq = 1'b0;
        irq_ack = 1'b0;
        osc = 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wait_core(3);
        t_reg();
        t_fifo();
        t_cmd();
        t_pd();
        report_and_stop();
    end
endmodule
